// ==== hdl/spi_pkg.sv ====
// Purpose: Shared constants and types of the SPI FIFO and event block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Flag positions are shared by event, enable and wake registers
package spi_pkg;

  localparam int ADDR_W = 6;
  localparam int DEPTH  = 32;
  localparam int PTR_W  = 5;
  localparam int CNT_W  = 6;
  localparam int NFLAG  = 12;
  localparam int NWAKE  = 4;

  localparam logic [ADDR_W-1:0] OFF_DATA  = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL0 = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL2 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_SSTIM = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_CLK   = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_DMA   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 6'h20;
  localparam logic [ADDR_W-1:0] OFF_EN    = 6'h24;
  localparam logic [ADDR_W-1:0] OFF_WKFL  = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_WKEN  = 6'h2C;
  localparam logic [ADDR_W-1:0] OFF_STAT  = 6'h30;
  localparam logic [ADDR_W-1:0] OFF_RDW   = 6'h34;

  // Event flag positions
  localparam int FL_TX_EMPTY = 0;
  localparam int FL_TX_TH    = 1;
  localparam int FL_RX_FULL  = 2;
  localparam int FL_RX_TH    = 3;
  localparam int FL_TX_OVR   = 4;
  localparam int FL_RX_UND   = 5;
  localparam int FL_TX_UND   = 6;
  localparam int FL_RX_OVR   = 7;
  localparam int FL_SS_EDGE  = 8;
  localparam int FL_DONE     = 9;
  localparam int FL_ABORT    = 10;
  localparam int FL_FAULT    = 11;

  localparam int EN_BIT    = 0;
  localparam int CTL_BIT   = 1;
  localparam int TXTH_LSB  = 0;
  localparam int RXTH_LSB  = 8;
  localparam int TXCNT_LSB = 0;
  localparam int RXCNT_LSB = 8;
  localparam int BUSY_BIT  = 16;

  localparam logic [31:0] RST_WORD   = 32'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVER = 2'h2;

  typedef enum logic [1:0] {W_BYTE, W_HALF, W_WORD, W_BAD} width_type;

  typedef struct packed {
    logic sck;
    logic ss_n;
    logic mosi;
    logic fault_n;
  } pins_type;

  localparam pins_type PIN_IDLE = 4'h5;

endpackage

// ==== hdl/spi_fifo_event.sv ====
// Purpose: SPI port FIFOs, access packing, event and wake flags
// Assumes: aclk 100 MHz; serial pins asynchronous, mode 0 target shifter
// Notes:   Controller SCK generation lives outside; it obeys sck_stall
`timescale 1ns/1ps
module spi_fifo_event (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [spi_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [spi_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic                      sck,
  input  wire logic                      ss_n,
  input  wire logic                      mosi,
  input  wire logic                      fault_n,
  input  wire logic                      xfer_done,
  output logic                           miso,
  output logic                           miso_oe,
  output logic                           sck_stall,
  output logic                           wake_req
);

  localparam int CW = spi_pkg::CNT_W;
  localparam int PW = spi_pkg::PTR_W;
  localparam logic [CW-1:0] FULL_CNT = CW'(spi_pkg::DEPTH);

  function automatic spi_pkg::width_type width_of(input logic [3:0] s);
    case (s)
      4'h1, 4'h2, 4'h4, 4'h8: width_of = spi_pkg::W_BYTE;
      4'h3, 4'hC:             width_of = spi_pkg::W_HALF;
      4'hF:                   width_of = spi_pkg::W_WORD;
      default:                width_of = spi_pkg::W_BAD;
    endcase
  endfunction

  function automatic logic [2:0] bytes_of(input spi_pkg::width_type w);
    case (w)
      spi_pkg::W_BYTE: bytes_of = 3'h1;
      spi_pkg::W_HALF: bytes_of = 3'h2;
      spi_pkg::W_WORD: bytes_of = 3'h4;
      default:         bytes_of = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        merge[8*i +: 8] = d[8*i +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  spi_pkg::pins_type pin_s1;
  spi_pkg::pins_type pin_s2;
  spi_pkg::pins_type pin_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= spi_pkg::PIN_IDLE;
      pin_s2 <= spi_pkg::PIN_IDLE;
      pin_d  <= spi_pkg::PIN_IDLE;
    end else begin
      pin_s1 <= {sck, ss_n, mosi, fault_n};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic ss_fall;
  logic ss_rise;
  logic fault_fall;
  assign sck_rise   = pin_s2.sck & ~pin_d.sck;
  assign sck_fall   = ~pin_s2.sck & pin_d.sck;
  assign ss_fall    = ~pin_s2.ss_n & pin_d.ss_n;
  assign ss_rise    = pin_s2.ss_n & ~pin_d.ss_n;
  assign fault_fall = ~pin_s2.fault_n & pin_d.fault_n;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave handshakes
  logic                      aw_held;
  logic                      w_held;
  logic [spi_pkg::ADDR_W-1:0] w_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;
  logic                      do_write;
  logic                      ar_hs;
  logic [spi_pkg::ADDR_W-1:0] r_addr;
  logic                      w_known;
  logic                      r_known;

  assign awready  = ~aw_held & ~bvalid;
  assign wready   = ~w_held & ~bvalid;
  assign arready  = ~rvalid;
  assign do_write = aw_held & w_held & ~bvalid;
  assign ar_hs    = arvalid & arready;
  assign r_addr   = {araddr[spi_pkg::ADDR_W-1:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      w_addr  <= '0;
      w_data  <= spi_pkg::RST_WORD;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= spi_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        w_addr  <= {awaddr[spi_pkg::ADDR_W-1:2], 2'h0};
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= w_known ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVER;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Software registers, one private set per instance
  // private register set
  logic [31:0]         ctrl0;
  logic [31:0]         ctrl1;
  logic [31:0]         ctrl2;
  logic [31:0]         sstime;
  logic [31:0]         clkcfg;
  logic [31:0]         dma_cfg;
  logic [31:0]         ev_en;
  logic [31:0]         wk_en;
  spi_pkg::width_type  rd_width;
  logic                en;
  logic                ctl_mode;
  logic                en_t;

  assign en       = ctrl0[spi_pkg::EN_BIT];
  assign ctl_mode = ctrl0[spi_pkg::CTL_BIT];
  assign en_t     = en & ~ctl_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0    <= spi_pkg::RST_WORD;
      ctrl1    <= spi_pkg::RST_WORD;
      ctrl2    <= spi_pkg::RST_WORD;
      sstime   <= spi_pkg::RST_WORD;
      clkcfg   <= spi_pkg::RST_WORD;
      dma_cfg  <= spi_pkg::RST_WORD;
      ev_en    <= spi_pkg::RST_WORD;
      wk_en    <= spi_pkg::RST_WORD;
      rd_width <= spi_pkg::W_WORD;
    end else if (do_write) begin
      case (w_addr)
        spi_pkg::OFF_CTRL0: ctrl0   <= merge(ctrl0, w_data, w_strb);
        spi_pkg::OFF_CTRL1: ctrl1   <= merge(ctrl1, w_data, w_strb);
        spi_pkg::OFF_CTRL2: ctrl2   <= merge(ctrl2, w_data, w_strb);
        spi_pkg::OFF_SSTIM: sstime  <= merge(sstime, w_data, w_strb);
        spi_pkg::OFF_CLK:   clkcfg  <= merge(clkcfg, w_data, w_strb);
        spi_pkg::OFF_DMA:   dma_cfg <= merge(dma_cfg, w_data, w_strb);
        spi_pkg::OFF_EN:    ev_en   <= merge(ev_en, w_data, w_strb);
        spi_pkg::OFF_WKEN:  wk_en   <= merge(wk_en, w_data, w_strb);
        spi_pkg::OFF_RDW: begin
          if (w_strb[0] && w_data[1:0] != spi_pkg::W_BAD) begin
            rd_width <= spi_pkg::width_type'(w_data[1:0]);
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit packing and queue
  logic [7:0]    tx_mem [spi_pkg::DEPTH];
  logic [PW-1:0] tx_wp;
  logic [PW-1:0] tx_rp;
  logic [CW-1:0] tx_count;
  logic [7:0]    part_lo;
  logic [7:0]    part_hi;
  logic          have_lo;
  logic          have_hi;
  logic [7:0]    next_part_lo;
  logic [7:0]    next_part_hi;
  logic          next_have_lo;
  logic          next_have_hi;
  logic [2:0]    wr_n;
  logic [31:0]   wr_bytes;
  logic [1:0]    lane;
  logic          wr_data;
  logic          tx_ovr;
  logic          tx_push;
  logic          tx_pop;

  assign wr_data = do_write && w_addr == spi_pkg::OFF_DATA;

  always_comb begin
    next_part_lo = part_lo;
    next_part_hi = part_hi;
    next_have_lo = have_lo;
    next_have_hi = have_hi;
    wr_n         = 3'h0;
    wr_bytes     = 32'h0;
    lane         = 2'h0;
    if (wr_data) begin
      case (width_of(w_strb))
        // word as four bytes, low byte first
        spi_pkg::W_WORD: begin
          wr_n     = bytes_of(spi_pkg::W_WORD);
          wr_bytes = w_data;
        end
        spi_pkg::W_HALF: begin
          wr_n     = bytes_of(spi_pkg::W_HALF);
          wr_bytes = {16'h0, w_strb[0] ? w_data[15:0] : w_data[31:16]};
        end
        spi_pkg::W_BYTE: begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) begin
              lane = 2'(i);
            end
          end
          if (lane[0]) begin
            next_part_hi = w_data[8*lane +: 8];
            next_have_hi = 1'b1;
          end else begin
            next_part_lo = w_data[8*lane +: 8];
            next_have_lo = 1'b1;
          end
          if (next_have_lo && next_have_hi) begin
            wr_n         = bytes_of(spi_pkg::W_HALF);
            wr_bytes     = {16'h0, next_part_hi, next_part_lo};
            next_have_lo = 1'b0;
            next_have_hi = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // Writes to a full queue are dropped whole, never split
  assign tx_ovr  = wr_n != 3'h0 && ({1'b0, tx_count} + 7'(wr_n)) > 7'(FULL_CNT);
  assign tx_push = wr_n != 3'h0 && !tx_ovr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      part_lo <= 8'h0;
      part_hi <= 8'h0;
      have_lo <= 1'b0;
      have_hi <= 1'b0;
    end else begin
      part_lo <= next_part_lo;
      part_hi <= next_part_hi;
      have_lo <= next_have_lo;
      have_hi <= next_have_hi;
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (tx_push && 3'(i) < wr_n) begin
        tx_mem[tx_wp + PW'(i)] <= wr_bytes[8*i +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_wp    <= '0;
      tx_rp    <= '0;
      tx_count <= '0;
    end else begin
      if (tx_push) begin
        tx_wp <= tx_wp + PW'(wr_n);
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + PW'(1);
      end
      tx_count <= tx_count + (tx_push ? CW'(wr_n) : '0) - CW'(tx_pop);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive queue and read path
  logic [7:0]    rx_mem [spi_pkg::DEPTH];
  logic [PW-1:0] rx_wp;
  logic [PW-1:0] rx_rp;
  logic [CW-1:0] rx_count;
  logic [2:0]    rd_n;
  logic [31:0]   rx_peek;
  logic          rd_data;
  logic          rx_und;
  logic          rx_pop;
  logic          rx_push;
  logic          rx_ovr;
  logic [7:0]    rx_byte;
  logic          sh_done;
  logic [31:0]   rd_word;
  logic [spi_pkg::NFLAG-1:0] flags;
  logic [spi_pkg::NWAKE-1:0] wk_fl;
  logic [2:0]    bitcnt;

  assign rd_n    = bytes_of(rd_width);
  assign rd_data = ar_hs && r_addr == spi_pkg::OFF_DATA;
  assign rx_und  = rd_data && rx_count < CW'(rd_n);
  assign rx_pop  = rd_data && !rx_und;
  assign rx_push = sh_done && rx_count != FULL_CNT;
  assign rx_ovr  = sh_done && rx_count == FULL_CNT;

  always_comb begin
    rx_peek = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < rd_n) begin
        rx_peek[8*i +: 8] = rx_mem[rx_rp + PW'(i)];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0;
    r_known = 1'b1;
    case (r_addr)
      spi_pkg::OFF_DATA:  rd_word = rx_und ? 32'h0 : rx_peek;
      spi_pkg::OFF_CTRL0: rd_word = ctrl0;
      spi_pkg::OFF_CTRL1: rd_word = ctrl1;
      spi_pkg::OFF_CTRL2: rd_word = ctrl2;
      spi_pkg::OFF_SSTIM: rd_word = sstime;
      spi_pkg::OFF_CLK:   rd_word = clkcfg;
      spi_pkg::OFF_DMA:   rd_word = dma_cfg;
      spi_pkg::OFF_FLAGS: rd_word[spi_pkg::NFLAG-1:0] = flags;
      spi_pkg::OFF_EN:    rd_word = ev_en;
      spi_pkg::OFF_WKFL:  rd_word[spi_pkg::NWAKE-1:0] = wk_fl;
      spi_pkg::OFF_WKEN:  rd_word = wk_en;
      spi_pkg::OFF_STAT: begin
        rd_word[spi_pkg::TXCNT_LSB +: CW] = tx_count;
        rd_word[spi_pkg::RXCNT_LSB +: CW] = rx_count;
        rd_word[spi_pkg::BUSY_BIT]        = bitcnt != 3'h0;
      end
      spi_pkg::OFF_RDW:   rd_word[1:0] = rd_width;
      default:            r_known = 1'b0;
    endcase
  end

  always_comb begin
    case (w_addr)
      spi_pkg::OFF_STAT: w_known = 1'b1;
      default: begin
        w_known = w_addr <= spi_pkg::OFF_RDW && w_addr != 6'h18;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= spi_pkg::RST_WORD;
      rresp  <= spi_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= r_known ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVER;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (rx_push) begin
      rx_mem[rx_wp] <= rx_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wp    <= '0;
      rx_rp    <= '0;
      rx_count <= '0;
    end else begin
      if (rx_push) begin
        rx_wp <= rx_wp + PW'(1);
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + PW'(rd_n);
      end
      rx_count <= rx_count + CW'(rx_push) - (rx_pop ? CW'(rd_n) : '0);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Target shifter, mode 0, MSB first
  logic [6:0] rx_sh;
  logic [7:0] tx_sh;
  logic       active;
  logic       sh_load;
  logic       sh_first;
  logic       tx_loaded;
  logic       tx_und;

  assign active   = en_t & ~pin_s2.ss_n;
  assign sh_done  = active & sck_rise & bitcnt == 3'h7;
  assign rx_byte  = {rx_sh, pin_s2.mosi};
  assign sh_load  = en_t & (ss_fall | (active & sck_fall & bitcnt == 3'h0));
  // Pop on the first sampled bit, so a preload cut off by select stays queued
  assign sh_first = active & sck_rise & bitcnt == 3'h0;
  assign tx_pop   = sh_first & tx_loaded;
  assign tx_und   = sh_first & ~tx_loaded;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bitcnt  <= 3'h0;
      rx_sh   <= 7'h0;
      tx_sh   <= 8'h0;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
      tx_loaded <= 1'b0;
    end else begin
      miso_oe <= active;
      miso    <= tx_sh[7];
      if (!active) begin
        bitcnt <= 3'h0;
      end else if (sck_rise) begin
        rx_sh  <= rx_byte[6:0];
        bitcnt <= bitcnt + 3'h1;
      end
      if (sh_load) begin
        tx_sh     <= tx_count != '0 ? tx_mem[tx_rp] : 8'h0;
        tx_loaded <= tx_count != '0;
      end else if (active && sck_fall) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // controller waits for data or room
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_stall <= 1'b0;
    end else begin
      sck_stall <= en & ctl_mode & (tx_count == '0 | rx_count == FULL_CNT);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event and wake flags
  logic [spi_pkg::NWAKE-1:0] cond;
  logic [spi_pkg::NWAKE-1:0] cond_q;
  logic [spi_pkg::NFLAG-1:0] ev;
  logic [spi_pkg::NFLAG-1:0] clr;
  logic [spi_pkg::NWAKE-1:0] wclr;
  logic [spi_pkg::NWAKE-1:0] next_wk;

  assign cond[spi_pkg::FL_TX_EMPTY] = tx_count == '0;
  assign cond[spi_pkg::FL_TX_TH]    = tx_count <= CW'(dma_cfg[spi_pkg::TXTH_LSB +: PW]);
  assign cond[spi_pkg::FL_RX_FULL]  = rx_count == FULL_CNT;
  assign cond[spi_pkg::FL_RX_TH]    = rx_count >= CW'(dma_cfg[spi_pkg::RXTH_LSB +: PW]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_q <= '1;
    end else begin
      cond_q <= cond;
    end
  end

  always_comb begin
    ev = '0;
    ev[spi_pkg::NWAKE-1:0]      = cond & ~cond_q;
    ev[spi_pkg::FL_TX_OVR]      = tx_ovr;
    ev[spi_pkg::FL_RX_UND]      = rx_und;
    ev[spi_pkg::FL_TX_UND]      = tx_und;
    ev[spi_pkg::FL_RX_OVR]      = rx_ovr;
    ev[spi_pkg::FL_SS_EDGE]     = en_t & (ss_fall | ss_rise);
    ev[spi_pkg::FL_DONE]        = en & ctl_mode & xfer_done;
    ev[spi_pkg::FL_ABORT]       = en_t & ss_rise & bitcnt != 3'h0;
    ev[spi_pkg::FL_FAULT]       = en & ctl_mode & fault_fall;
  end

  assign clr  = do_write && w_addr == spi_pkg::OFF_FLAGS ?
                w_data[spi_pkg::NFLAG-1:0] : '0;
  assign wclr = do_write && w_addr == spi_pkg::OFF_WKFL ?
                w_data[spi_pkg::NWAKE-1:0] : '0;
  assign next_wk = (wk_fl & ~wclr) |
                   (ev[spi_pkg::NWAKE-1:0] & wk_en[spi_pkg::NWAKE-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags    <= '0;
      wk_fl    <= '0;
      wake_req <= 1'b0;
    end else begin
      flags    <= (flags & ~clr) | ev;
      wk_fl    <= next_wk;
      wake_req <= |next_wk;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  flag_set_a: assert property ((|ev) |=> ((flags & $past(ev)) == $past(ev)))
    else $error("event did not set its flag");
  flag_once_a: assert property ((flags[spi_pkg::NWAKE-1:0]
      & $past(cond & cond_q & ~flags[spi_pkg::NWAKE-1:0])) == '0)
    else $error("flag retriggered while condition held");
  w1c_clear_a: assert property ((clr[0] && !ev[0]) |=> !flags[0])
    else $error("write one did not clear flag");
  half_push_a: assert property (wr_data && width_of(w_strb) == spi_pkg::W_HALF
      && !tx_ovr && !tx_pop |=> tx_count == $past(tx_count) + CW'(2))
    else $error("halfword write did not add two bytes");
  word_push_a: assert property (wr_data && width_of(w_strb) == spi_pkg::W_WORD
      && !tx_ovr && !tx_pop |=> tx_count == $past(tx_count) + CW'(4))
    else $error("word write did not add four bytes");
  rx_pop_a: assert property (rx_pop && !rx_push
      |=> rx_count == $past(rx_count) - CW'($past(rd_n)))
    else $error("read removed wrong byte count");
  tx_und_a: assert property (ev[spi_pkg::FL_TX_UND] |-> !ctl_mode)
    else $error("underrun raised in controller mode");
  wake_gate_a: assert property ((wk_fl & ~$past(wk_fl)
      & ~$past(wk_en[spi_pkg::NWAKE-1:0])) == '0)
    else $error("wake flag set while disabled");
  occ_bound_a: assert property (tx_count <= FULL_CNT && rx_count <= FULL_CNT)
    else $error("queue count beyond depth");

endmodule

// ==== test/spi_peer.sv ====
// Purpose: Mode 0 SPI controller model driving the target port
// Assumes: 80 ns serial clock, one byte per select frame, MSB first
// Notes:   Clock stands low between frames; mosi toggles when released
`timescale 1ns/1ps
module spi_peer (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [7:0] o, output logic [7:0] i);
    #83 ss_n = 1'b0;
    // Extra setup so the synced select edge loads the shifter
    #40;
    for (int b = 7; b >= 0; b--) begin
      mosi = o[b];
      #40 sck = 1'b1;
      i[b] = miso;
      #40 sck = 1'b0;
    end
    #40 mosi = ~mosi;
    ss_n = 1'b1;
    #40;
  endtask
endmodule

// ==== test/tb_spi_fifo_event.sv ====
// Purpose: Self-checking bench for the SPI FIFO and event block
// Assumes: spi_peer plays the external controller
// Notes:   Ready and answers sampled at the falling edge to avoid races
`timescale 1ns/1ps
module tb_spi_fifo_event;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, lb, lr;
  logic awready, wready, bvalid, arready, rvalid, sck, ss_n, mosi, miso, miso_oe, sck_stall, wake_req;
  logic [7:0] got;
  logic fault_n = 1, xfer_done = 0;
  int n_fail = 0, checks = 0, cyc = 0;
  spi_fifo_event u_dut (.*);
  spi_peer u_peer (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(negedge aclk) {ta, tw} = {awready & pa, wready & pw};
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    lb = bresp;
    @(posedge aclk) bready <= 1'b0;
  endtask
  task rdc(input string n, input logic [5:0] a, input logic [31:0] e);
    @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk) arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    lr = rresp;
    chk(n, rdata, e);
    @(posedge aclk) rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_word();
    wr(spi_pkg::OFF_DATA, 32'h44332211, 4'hF);
    rdc("tx count", spi_pkg::OFF_STAT, 32'h4);
    for (int k = 0; k < 4; k++) begin
      u_peer.xfer(8'hA0 + k, got);
      chk("miso byte", {24'h0, got}, 8'h11 * (k + 1));
    end
    rdc("rx count", spi_pkg::OFF_STAT, 32'h400);
    rdc("word read", spi_pkg::OFF_DATA, 32'hA3A2A1A0);
    chk("wake", {31'h0, wake_req}, 32'h1);
    rdc("flags", spi_pkg::OFF_FLAGS, 32'h103);
    wr(spi_pkg::OFF_FLAGS, 32'hFFF, 4'hF);
    rdc("cleared", spi_pkg::OFF_FLAGS, 32'h0);
  endtask
  task t_bytes();
    logic [7:0] ex [4];
    ex = '{8'hAA, 8'hBB, 8'h11, 8'h22};
    wr(spi_pkg::OFF_DATA, 32'h0000BB00, 4'h2);
    rdc("held", spi_pkg::OFF_STAT, 32'h0);
    wr(spi_pkg::OFF_DATA, 32'h000000AA, 4'h1);
    wr(spi_pkg::OFF_DATA, 32'h00002211, 4'h3);
    rdc("half count", spi_pkg::OFF_STAT, 32'h4);
    for (int k = 0; k < 4; k++) begin
      u_peer.xfer(8'hC0 + k, got);
      chk("miso byte", {24'h0, got}, ex[k]);
    end
    wr(spi_pkg::OFF_RDW, 32'h1, 4'hF);
    rdc("half read", spi_pkg::OFF_DATA, 32'h0000C1C0);
    wr(spi_pkg::OFF_RDW, 32'h0, 4'hF);
    rdc("byte read", spi_pkg::OFF_DATA, 32'hC2);
    rdc("rx left", spi_pkg::OFF_STAT, 32'h100);
  endtask
  task t_ctl();
    wr(spi_pkg::OFF_CTRL0, 32'h3, 4'hF);
    @(posedge aclk) xfer_done <= 1'b1;
    @(posedge aclk) xfer_done <= 1'b0;
    fault_n <= 1'b0;
    repeat (4) @(posedge aclk);
    fault_n <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("stall", {31'h0, sck_stall}, 32'h1);
    chk("miso oe", {31'h0, miso_oe}, 32'h0);
    rdc("ctl flags", spi_pkg::OFF_FLAGS, 32'hB03);
    wr(spi_pkg::OFF_FLAGS, 32'hA00, 4'hF);
    wr(spi_pkg::OFF_CTRL0, 32'h1, 4'hF);
    rdc("kept flags", spi_pkg::OFF_FLAGS, 32'h103);
    chk("no stall", {31'h0, sck_stall}, 32'h0);
  endtask
  task t_misuse();
    wr(spi_pkg::OFF_RDW, 32'h2, 4'hF);
    rdc("short read", spi_pkg::OFF_DATA, 32'h0);
    rdc("underrun", spi_pkg::OFF_FLAGS, 32'h123);
    wr(spi_pkg::OFF_FLAGS, 32'hFFF, 4'hF);
    for (int k = 0; k < 9; k++) wr(spi_pkg::OFF_DATA, 32'h03020100 + k, 4'hF);
    rdc("full", spi_pkg::OFF_STAT, 32'h120);
    rdc("overrun", spi_pkg::OFF_FLAGS, 32'h10);
    wr(6'h18, 32'h1, 4'hF);
    chk("bresp", {30'h0, lb}, spi_pkg::RESP_SLVER);
    rdc("hole", 6'h18, 32'h0);
    chk("rresp", {30'h0, lr}, spi_pkg::RESP_SLVER);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("enables", spi_pkg::OFF_EN, 32'h0);
    wr(spi_pkg::OFF_CTRL0, 32'h1, 4'hF);
    wr(spi_pkg::OFF_WKEN, 32'h1, 4'hF);
    t_word();
    t_bytes();
    t_ctl();
    t_misuse();
    close_out();
  end
endmodule
